// *** verilog/cam_capture_pkg.sv ***
package cam_capture_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [11:0] IDX_MODULE_SETTING = 12'h110;
    localparam logic [11:0] IDX_MODE           = 12'h112;
    localparam logic [11:0] IDX_CMD            = 12'h114;
    localparam logic [11:0] IDX_STATUS         = 12'h116;
    localparam logic [11:0] IDX_FLASH_DELAY    = 12'h120;

    localparam logic [15:0] MODULE_SETTING_RST = 16'h0000;
    localparam logic [7:0]  MODE_RST           = 8'h00;
    localparam logic [15:0] FLASH_DELAY_RST    = 16'h0000;

    // Module setting fields.
    localparam int BIT_MOD_EN   = 0;
    localparam int BIT_BT656_EN = 7;

    // Capture mode fields.
    localparam int BIT_INT_EN   = 0;
    localparam int BIT_TRIG_POL = 1;
    localparam int DEC_LSB      = 2;
    localparam int BIT_ALWAYS   = 5;
    localparam int BIT_SINGLE   = 6;
    localparam int BIT_INT_CTRL = 7;
    localparam logic [2:0] DEC_RESERVED = 3'h7;

    // Command strobe fields.
    localparam int BIT_SRST     = 0;
    localparam int BIT_INT_CLR  = 1;
    localparam int BIT_START    = 2;
    localparam int BIT_STOP     = 3;
    localparam int BIT_ERR0_CLR = 8;
    localparam int BIT_ERR1_CLR = 9;

    // Status fields.
    localparam int ST_INT       = 1;
    localparam int ST_STARTED   = 2;
    localparam int ST_BUSY      = 3;
    localparam int ST_EFFECTIVE = 4;
    localparam int ST_VSYNC     = 6;
    localparam int ST_ERR0      = 8;
    localparam int ST_ERR1      = 9;

    // Reference code preamble of the embedded-sync stream.
    localparam logic [23:0] REF_PREAMBLE = 24'hff0000;

    // Camera clock output timing.
    localparam int PCLK_PERIOD_NS    = 8;
    localparam int CAM_CLK_PERIOD_NS = 64;
    localparam int CAM_CLK_HALF_CYC  = CAM_CLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

    typedef enum logic [2:0] {
        CS_IDLE  = 3'b001,
        CS_ARMED = 3'b010,
        CS_BUSY  = 3'b100
    } cap_e;

endpackage : cam_capture_pkg

// *** verilog/camera_frame_capture_control.sv ***
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module camera_frame_capture_control #(
    parameter int CLK_HALF = cam_capture_pkg::CAM_CLK_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cam_pclk_in,
    input  wire logic        cam_vsync,
    input  wire logic [7:0]  cam_data,
    input  wire logic        jpeg_run,
    output logic             first_port_clock_out,
    output logic             second_port_clock_out,
    output logic             frame_irq
);
    import cam_capture_pkg::*;

    typedef struct packed {
        logic [15:0] module_set;
        logic [7:0]  mode;
        logic [15:0] flash_delay;
        logic [2:0]  clk_sy;
        logic [2:0]  vs_sy;
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic [7:0]  d3;
        logic        clk_lvl;
        logic        vs_lvl;
        logic        vs_prev;
        logic [23:0] hist;
        logic        bt_v;
        cap_e        cap;
        logic [2:0]  dec_cnt;
        logic        effective;
        logic        captured_any;
        logic        first_pend;
        logic        done_pend;
        logic        int_st;
        logic        err0;
        logic        err1;
        logic [7:0]  div_cnt;
        logic        clk_out;
        logic [31:0] rdata;
        logic        slverr;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [11:0] idx;
    logic        addr_ok;
    logic        setup_ph;
    logic        wr_acc;
    logic        wr_cmd;
    logic [15:0] wdata;
    logic        clk_rise;
    logic        vs_now;
    logic        frame_start;
    logic        frame_end;
    logic        fire;
    logic        qual;
    logic        set_int;
    logic        set_err0;
    logic        set_err1;
    logic [3:0]  par;
    logic [2:0]  mism;
    logic [2:0]  dec_sel;
    logic        mod_en;
    logic        bt_en;
    logic        single;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and outputs.

    assign idx      = paddr[13:2];
    assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0) &&
                      (idx == IDX_MODULE_SETTING || idx == IDX_MODE || idx == IDX_CMD ||
                       idx == IDX_STATUS || idx == IDX_FLASH_DELAY);
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite && addr_ok;
    assign wr_cmd   = wr_acc && (idx == IDX_CMD);
    assign wdata    = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

    // Zero wait states: read data is captured at the setup edge.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && st_r.slverr;
    assign prdata  = st_r.rdata;

    assign first_port_clock_out  = st_r.clk_out;
    assign second_port_clock_out = st_r.clk_out;
    assign frame_irq             = st_r.int_st && st_r.mode[BIT_INT_EN];

    assign mod_en  = st_r.module_set[BIT_MOD_EN];
    assign bt_en   = st_r.module_set[BIT_BT656_EN];
    assign single  = st_r.mode[BIT_SINGLE];
    assign dec_sel = st_r.mode[DEC_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // Camera side event detection.

    // The sampled clock counts only once stages two and three agree.
    assign clk_rise = (st_r.clk_sy[1] == st_r.clk_sy[2]) && st_r.clk_sy[2] && !st_r.clk_lvl;

    // In embedded-sync mode the vertical flag comes from the reference codes.
    assign vs_now      = bt_en ? st_r.bt_v : st_r.vs_lvl;
    assign frame_start = mod_en && st_r.vs_prev && !vs_now;
    assign frame_end   = mod_en && !st_r.vs_prev && vs_now;

    // Hamming protection of the reference code: F=6, V=5, H=4.
    assign par  = {st_r.d3[5] ^ st_r.d3[4], st_r.d3[6] ^ st_r.d3[4],
                   st_r.d3[6] ^ st_r.d3[5], st_r.d3[6] ^ st_r.d3[5] ^ st_r.d3[4]};
    assign mism = 3'({2'h0, !st_r.d3[7]}) + 3'({2'h0, par[3] ^ st_r.d3[3]}) +
                  3'({2'h0, par[2] ^ st_r.d3[2]}) + 3'({2'h0, par[1] ^ st_r.d3[1]}) +
                  3'({2'h0, par[0] ^ st_r.d3[0]});
    assign set_err0 = bt_en && clk_rise && st_r.hist == REF_PREAMBLE && mism == 3'h1;
    assign set_err1 = bt_en && clk_rise && st_r.hist == REF_PREAMBLE && mism >= 3'h2;

    // Polarity 0 triggers as vsync turns inactive, 1 as it turns active.
    assign fire = (st_r.mode[BIT_TRIG_POL] ? frame_start : frame_end) &&
                  (st_r.done_pend || (frame_end && st_r.cap == CS_BUSY));

    always_comb begin
        if (single) begin
            qual = 1'b1;
        end else if (st_r.mode[BIT_INT_CTRL]) begin
            qual = 1'b0;
        end else begin
            qual = st_r.mode[BIT_ALWAYS] || (jpeg_run && st_r.first_pend);
        end
    end

    // A continuous run with control set reports when stopped after a frame.
    assign set_int = st_r.mode[BIT_INT_EN] &&
                     ((fire && qual) ||
                      (!single && st_r.mode[BIT_INT_CTRL] && wr_cmd &&
                       wdata[BIT_STOP] && st_r.captured_any));

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_nxt = st_r;
        st_nxt.clk_sy = {st_r.clk_sy[1:0], cam_pclk_in};
        st_nxt.vs_sy  = {st_r.vs_sy[1:0], cam_vsync};
        st_nxt.d1     = cam_data;
        st_nxt.d2     = st_r.d1;
        st_nxt.d3     = st_r.d2;
        if (st_r.clk_sy[1] == st_r.clk_sy[2]) begin
            st_nxt.clk_lvl = st_r.clk_sy[2];
        end
        if (st_r.vs_sy[1] == st_r.vs_sy[2]) begin
            st_nxt.vs_lvl = st_r.vs_sy[2];
        end
        st_nxt.vs_prev = vs_now;

        if (clk_rise && bt_en) begin
            st_nxt.hist = {st_r.hist[15:0], st_r.d3};
            if (st_r.hist == REF_PREAMBLE && mism == 3'h0) begin
                st_nxt.bt_v = st_r.d3[5];
            end
        end

        // Decimation counts every frame while the module runs.
        if (frame_start) begin
            st_nxt.effective = (st_r.dec_cnt == 3'h0);
            if (dec_sel == DEC_RESERVED || st_r.dec_cnt >= dec_sel) begin
                st_nxt.dec_cnt = 3'h0;
            end else begin
                st_nxt.dec_cnt = st_r.dec_cnt + 3'h1;
            end
            if (st_r.cap == CS_ARMED && st_r.dec_cnt == 3'h0) begin
                st_nxt.cap = CS_BUSY;
            end
        end
        if (frame_end) begin
            st_nxt.effective = 1'b0;
            if (st_r.cap == CS_BUSY) begin
                st_nxt.captured_any = 1'b1;
                st_nxt.done_pend    = 1'b1;
                st_nxt.cap          = single ? CS_IDLE : CS_ARMED;
            end
        end
        if (fire) begin
            st_nxt.done_pend = 1'b0;
            if (qual) begin
                st_nxt.first_pend = 1'b0;
            end
        end

        if (wr_cmd && wdata[BIT_STOP]) begin
            st_nxt.cap = CS_IDLE;
        end else if (wr_cmd && wdata[BIT_START] && mod_en && st_r.cap == CS_IDLE) begin
            st_nxt.cap          = CS_ARMED;
            st_nxt.captured_any = 1'b0;
            st_nxt.first_pend   = 1'b1;
        end

        // Set wins over a clear in the same cycle.
        if (set_int) begin
            st_nxt.int_st = 1'b1;
        end else if (wr_cmd && wdata[BIT_INT_CLR]) begin
            st_nxt.int_st = 1'b0;
        end
        if (set_err0) begin
            st_nxt.err0 = 1'b1;
        end else if (wr_cmd && wdata[BIT_ERR0_CLR] && bt_en) begin
            st_nxt.err0 = 1'b0;
        end
        if (set_err1) begin
            st_nxt.err1 = 1'b1;
        end else if (wr_cmd && wdata[BIT_ERR1_CLR] && bt_en) begin
            st_nxt.err1 = 1'b0;
        end

        if (mod_en) begin
            if (st_r.div_cnt == 8'(CLK_HALF - 1)) begin
                st_nxt.div_cnt = 8'h00;
                st_nxt.clk_out = !st_r.clk_out;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 8'h01;
            end
        end else begin
            st_nxt.div_cnt   = 8'h00;
            st_nxt.clk_out   = 1'b0;
            st_nxt.cap       = CS_IDLE;
            st_nxt.effective = 1'b0;
            st_nxt.done_pend = 1'b0;
            st_nxt.dec_cnt   = 3'h0;
        end

        // Soft reset clears capture state but keeps every setting.
        if (wr_cmd && wdata[BIT_SRST]) begin
            st_nxt.cap          = CS_IDLE;
            st_nxt.dec_cnt      = 3'h0;
            st_nxt.effective    = 1'b0;
            st_nxt.captured_any = 1'b0;
            st_nxt.first_pend   = 1'b0;
            st_nxt.done_pend    = 1'b0;
            st_nxt.int_st       = 1'b0;
            st_nxt.err0         = 1'b0;
            st_nxt.err1         = 1'b0;
            st_nxt.hist         = 24'h000000;
            st_nxt.bt_v         = 1'b0;
        end

        // Configuration writes.
        if (wr_acc && idx == IDX_MODULE_SETTING) begin
            st_nxt.module_set = wdata;
        end
        if (wr_acc && idx == IDX_MODE) begin
            st_nxt.mode = wdata[7:0];
        end
        if (wr_acc && idx == IDX_FLASH_DELAY) begin
            st_nxt.flash_delay = wdata;
        end

        // Read data and error answer are prepared in the setup phase.
        if (setup_ph) begin
            st_nxt.slverr = !addr_ok;
            st_nxt.rdata  = 32'h00000000;
            if (!pwrite && addr_ok) begin
                case (idx)
                    IDX_MODULE_SETTING: st_nxt.rdata = {16'h0000, st_r.module_set};
                    IDX_MODE:           st_nxt.rdata = {24'h000000, st_r.mode};
                    IDX_FLASH_DELAY:    st_nxt.rdata = {16'h0000, st_r.flash_delay};
                    IDX_STATUS: begin
                        st_nxt.rdata[ST_ERR1]      = st_r.err1;
                        st_nxt.rdata[ST_ERR0]      = st_r.err0;
                        st_nxt.rdata[ST_VSYNC]     = vs_now;
                        st_nxt.rdata[ST_EFFECTIVE] = st_r.effective;
                        st_nxt.rdata[ST_BUSY]      = (st_r.cap == CS_BUSY);
                        st_nxt.rdata[ST_STARTED]   = (st_r.cap != CS_IDLE);
                        st_nxt.rdata[ST_INT]       = frame_irq;
                    end
                    default: st_nxt.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r             <= '0;
            st_r.module_set  <= MODULE_SETTING_RST;
            st_r.mode        <= MODE_RST;
            st_r.flash_delay <= FLASH_DELAY_RST;
            st_r.cap         <= CS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_clock_gated: assert property (!mod_en |=> !first_port_clock_out)
        else $error("camera clock runs while module disabled");
    chk_stop_wins: assert property (wr_cmd && wdata[BIT_STOP] |=> st_r.cap == CS_IDLE)
        else $error("stop command left capture running");
    chk_start_arms: assert property (
        wr_cmd && wdata[BIT_START] && !wdata[BIT_STOP] && !wdata[BIT_SRST] && mod_en &&
        st_r.cap == CS_IDLE |=> st_r.cap == CS_ARMED)
        else $error("start command did not arm capture");
    chk_int_clear: assert property (
        wr_cmd && wdata[BIT_INT_CLR] && !set_int |=> !st_r.int_st)
        else $error("interrupt status not cleared");
    chk_int_gated: assert property ($rose(st_r.int_st) |-> $past(st_r.mode[BIT_INT_EN]))
        else $error("interrupt status set while disabled");
    chk_single_halt: assert property (
        frame_end && single && st_r.cap == CS_BUSY && !wr_cmd |=> st_r.cap == CS_IDLE)
        else $error("single frame capture did not halt");
    chk_every_frame: assert property (
        frame_start && dec_sel == 3'h0 |=> st_r.effective ##1 st_r.dec_cnt == 3'h0)
        else $error("decimation skipped a frame");
    chk_err_sticky: assert property (
        st_r.err1 && !wr_cmd |=> st_r.err1)
        else $error("error flag dropped without clear");
    chk_soft_reset: assert property (
        wr_cmd && wdata[BIT_SRST] |=> st_r.cap == CS_IDLE && $stable(st_r.mode))
        else $error("soft reset wrong");

    cov_single_irq: cover property (single && set_int);
    cov_stop_irq: cover property (!single && st_r.mode[BIT_INT_CTRL] && set_int);
    cov_bt_error: cover property (set_err0 || set_err1);
    cov_decimated: cover property (frame_start && dec_sel == 3'h2 ##[1:1000] frame_start);

endmodule : camera_frame_capture_control

// *** verification/cam_sensor_model.sv ***
`timescale 1ns/100ps
module cam_sensor_model (
    output logic       cam_pclk_in,
    output logic       cam_vsync,
    output logic [7:0] cam_data
);
    // The pixel clock stands still between bytes and frames.
    initial begin
        cam_pclk_in = 1'b0;
        cam_vsync   = 1'b1;
        cam_data    = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data turns to its inverse once the hold time is over, so a late
    // sample never sees a stale byte that happens to look right.
    task automatic put(input logic [7:0] b);
        cam_data <= b;
        #40 cam_pclk_in <= 1'b1;
        #20 cam_data <= ~b;
        #20 cam_pclk_in <= 1'b0;
    endtask : put

    task automatic vs(input logic v);
        cam_vsync <= v;
    endtask : vs
endmodule : cam_sensor_model

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
    import cam_capture_pkg::*;
    localparam logic [15:0] A_SET  = {2'b00, IDX_MODULE_SETTING, 2'b00};
    localparam logic [15:0] A_MODE = {2'b00, IDX_MODE, 2'b00};
    localparam logic [15:0] A_CMD  = {2'b00, IDX_CMD, 2'b00};
    localparam logic [15:0] A_ST   = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [15:0] A_FL   = {2'b00, IDX_FLASH_DELAY, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        jpeg_run, cam_pclk_in, cam_vsync, ck1, ck2, frame_irq, rerr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdata, st_mid, d;
    logic [3:0]  pstrb, wstrb;
    logic [7:0]  cam_data;
    int          num_errors, comparisons, c;

    camera_frame_capture_control #(.CLK_HALF(2)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cam_pclk_in(cam_pclk_in), .cam_vsync(cam_vsync), .cam_data(cam_data),
        .jpeg_run(jpeg_run), .first_port_clock_out(ck1),
        .second_port_clock_out(ck2), .frame_irq(frame_irq));
    cam_sensor_model cam (.cam_pclk_in(cam_pclk_in), .cam_vsync(cam_vsync),
                          .cam_data(cam_data));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Entered right after a rising edge; leaves one idle edge behind so
    // the next call never drives psel twice in one time step.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] v);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        pstrb   <= w ? wstrb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic cmd(input logic [31:0] v);
        apb(1'b1, A_CMD, v);
    endtask : cmd

    task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdata & m);
    endtask : rchk

    task automatic restart;
        cmd(32'h8);
        cmd(32'h4);
    endtask : restart

    task automatic set_mode(input logic [31:0] m);
        apb(1'b1, A_SET, 32'h0);
        apb(1'b1, A_MODE, m);
        apb(1'b1, A_SET, 32'h1);
    endtask : set_mode

    task automatic frame(input int n);
        cam.vs(1'b0);
        repeat (8) @(posedge pclk);
        apb(1'b0, A_ST, 32'h0);
        st_mid = rdata;
        chk("vsync_mid", 0, st_mid[ST_VSYNC]);
        repeat (n) cam.put(8'($urandom));
        cam.vs(1'b1);
        repeat (10) @(posedge pclk);
    endtask : frame

    task automatic irq_is(input logic e);
        apb(1'b0, A_ST, 32'h0);
        chk("frame_irq", e, frame_irq);
        chk("int_status", e, rdata[ST_INT]);
    endtask : irq_is

    task automatic ref_code(input logic [7:0] xy, input logic [1:0] e);
        cam.put(8'hff);
        cam.put(8'h00);
        cam.put(8'h00);
        cam.put(xy);
        repeat (10) @(posedge pclk);
        rchk("bt656_err", A_ST, 32'h300, {22'h0, e, 8'h0});
    endtask : ref_code

    task automatic toggles(output int n);
        logic [1:0] p;
        n = 0;
        p = {ck1, ck2};
        repeat (40) begin
            @(posedge pclk);
            n += int'(p[1] !== ck1) + int'(p[0] !== ck2);
            p = {ck1, ck2};
        end
    endtask : toggles

    function automatic logic [31:0] mode_w(input logic ie, pl, input logic [2:0] dc,
                                           input logic al, sg, ct);
        return {24'h0, ct, sg, al, dc, pl, ie};
    endfunction : mode_w

    function automatic logic eff_exp(input logic [2:0] dc, input int k);
        return (dc == DEC_RESERVED) || (k % (int'(dc) + 1) == 0);
    endfunction : eff_exp

    // A byte lane that is not strobed is written as zero.
    function automatic logic [31:0] lane_exp(input logic [31:0] v, input logic [3:0] s);
        return {16'h0, s[1] ? v[15:8] : 8'h00, s[0] ? v[7:0] : 8'h00};
    endfunction : lane_exp

    initial begin
        #600000;
        num_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 16'h0000;
        pwdata      = 32'h0;
        pstrb       = 4'h0;
        wstrb       = 4'hf;
        jpeg_run    = 1'b0;
        num_errors  = 0;
        comparisons = 0;
        void'($urandom(72225));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("mode_rst", A_MODE, 32'hffffffff, 32'h0);
        rchk("flash_rst", A_FL, 32'hffffffff, 32'h0);
        rchk("status_rst", A_ST, 32'h31e, 32'h0);
        rchk("cmd_read", A_CMD, 32'hffffffff, 32'h0);
        apb(1'b0, 16'h0444, 32'h0);
        chk("unmapped_err", 1, rerr);
        repeat (3) begin
            d     = $urandom;
            wstrb = 4'($urandom);
            apb(1'b1, A_FL, d);
            rchk("flash_rw", A_FL, 32'hffffffff, lane_exp(d, wstrb));
        end
        wstrb = 4'hf;
        apb(1'b1, A_ST, 32'hffff);
        rchk("status_ro", A_ST, 32'h31e, 32'h0);
        toggles(c);
        chk("clk_off", 0, c);
        set_mode(mode_w(1, 0, 3'h0, 1, 0, 0));
        toggles(c);
        chk("clk_on", 1, c >= 38 && c <= 40);
        cmd(32'h4);
        rchk("started", A_ST, 32'h4c, 32'h44);
        frame(3);
        chk("busy_eff", 2'b11, st_mid[4:3]);
        rchk("busy_end", A_ST, 32'h8, 32'h0);
        irq_is(1);
        cmd(32'h0);
        irq_is(1);
        apb(1'b1, A_MODE, mode_w(0, 0, 3'h0, 1, 0, 0));
        irq_is(0);
        cmd(32'h2);
        apb(1'b1, A_MODE, mode_w(1, 0, 3'h0, 1, 0, 0));
        irq_is(0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_MODE, mode_w(1, 0, i[2:0], 1, 0, 0));
            restart();
            for (int k = 0; k < (i == 7 ? 2 : 2 * i + 2); k++) begin
                // With always-active set the encoder level must not matter.
                jpeg_run <= 1'($urandom);
                frame(2 + $urandom % 3);
                chk("effective", eff_exp(i[2:0], k), st_mid[ST_EFFECTIVE]);
                irq_is(eff_exp(i[2:0], k));
                cmd(32'h2);
            end
        end
        jpeg_run <= 1'b1;
        apb(1'b1, A_MODE, mode_w(1, 0, 3'h0, 0, 0, 0));
        restart();
        frame(2);
        irq_is(1);
        cmd(32'h2);
        frame(2);
        irq_is(0);
        jpeg_run <= 1'b0;
        restart();
        frame(2);
        irq_is(0);
        apb(1'b1, A_MODE, mode_w(1, 0, 3'h0, 0, 0, 1));
        restart();
        // The stop inside restart reports the frame of the previous run.
        cmd(32'h2);
        frame(2);
        irq_is(0);
        cmd(32'h8);
        irq_is(1);
        chk("started_off", 0, rdata[ST_STARTED]);
        frame(2);
        chk("busy_stopped", 0, st_mid[ST_BUSY]);
        cmd(32'h2);
        set_mode(mode_w(1, 1, 3'h0, 1, 0, 0));
        cmd(32'h4);
        frame(2);
        irq_is(0);
        cam.vs(1'b0);
        repeat (8) @(posedge pclk);
        irq_is(1);
        cam.vs(1'b1);
        repeat (10) @(posedge pclk);
        cmd(32'h2);
        for (int ct = 0; ct < 2; ct++) begin
            set_mode(mode_w(1, 0, 3'h0, 0, 1, ct[0]));
            cmd(32'h4);
            frame(2);
            chk("single_busy", 1, st_mid[ST_BUSY]);
            irq_is(1);
            cmd(32'h2);
            frame(2);
            chk("single_halt", 0, st_mid[ST_BUSY]);
            irq_is(0);
        end
        set_mode(mode_w(0, 0, 3'h0, 1, 0, 0));
        cmd(32'h4);
        frame(2);
        irq_is(0);
        // Start from idle, so that the start half alone would arm capture.
        cmd(32'h8);
        cmd(32'hc);
        rchk("start_stop", A_ST, 32'h4, 32'h0);
        cmd(32'h4);
        cmd(32'h1);
        rchk("srst_started", A_ST, 32'h4, 32'h0);
        rchk("srst_cfg", A_MODE, 32'hff, mode_w(0, 0, 3'h0, 1, 0, 0));
        rchk("srst_set", A_SET, 32'hffff, 32'h1);
        apb(1'b1, A_SET, 32'h0);
        toggles(c);
        chk("clk_off2", 0, c);
        cmd(32'h4);
        rchk("start_disabled", A_ST, 32'h4, 32'h0);
        apb(1'b1, A_SET, 32'h81);
        ref_code(8'h80, 2'b00);
        ref_code(8'h81, 2'b01);
        ref_code(8'h83, 2'b11);
        cmd(32'h100);
        rchk("err0_clr", A_ST, 32'h300, 32'h200);
        apb(1'b1, A_SET, 32'h1);
        cmd(32'h200);
        apb(1'b1, A_SET, 32'h81);
        rchk("err1_kept", A_ST, 32'h300, 32'h200);
        report_and_stop();
    end
endmodule : tb
